/* mcr_avg_decode.sv */
// Priority decoder from averaging select to averages per reading
`timescale 1ns/100ps
module mcr_avg_decode
    import mcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    mcr_cfg_if.sink          cfg,
    output logic [7:0]       remote_avg_count,
    output logic [7:0]       local_avg_count
);

    logic [7:0]  next_remote;
    logic [7:0]  next_local;

    always_comb
    begin
        // Highest set bit wins; lower bits are don't-care
        if (cfg.averaging_select[MC_AVG_HI - MC_AVG_LO])            // RULE6
        begin
            next_remote = AVG_32;
            next_local  = AVG_32;
        end
        else if (cfg.averaging_select[MC_AVG_MID - MC_AVG_LO])      // RULE7
        begin
            next_remote = AVG_16;
            next_local  = AVG_16;
        end
        else if (cfg.averaging_select[0])
        begin
            next_remote = AVG_16;
            next_local  = AVG_1;
        end
        else
        begin
            next_remote = AVG_128;
            next_local  = AVG_8;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            remote_avg_count <= AVG_16;
            local_avg_count  <= AVG_16;
        end
        else
        begin
            remote_avg_count <= next_remote;
            local_avg_count  <= next_local;
        end
    end

endmodule : mcr_avg_decode

/* mcr_cfg_if.sv */
// Interface carrying decoded control fields between register and pin logic
`timescale 1ns/100ps
interface mcr_cfg_if;
    logic        irq_output_enable;
    logic        voltage_group_irq_enable;
    logic        speed3_pin_as_irq;
    logic        drive2_pin_as_irq;
    logic [2:0]  averaging_select;

    modport source (output irq_output_enable, voltage_group_irq_enable,
                    speed3_pin_as_irq, drive2_pin_as_irq, averaging_select);
    modport sink   (input  irq_output_enable, voltage_group_irq_enable,
                    speed3_pin_as_irq, drive2_pin_as_irq, averaging_select);
endinterface : mcr_cfg_if

/* mcr_host.sv */
// Register host model issuing strobed reads and writes
`timescale 1ns/100ps
module mcr_host
    import mcr_pkg::*;
(
    input  wire logic       clk,
    output logic            reg_write,
    output logic            reg_read,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == OFS_MON_CTRL)
            v[4:3] = 2'h0;
        if (a == OFS_DEV_CFG)
            v[6:5] = 2'h0;
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk);
        reg_write = 1'b0;
        // Released bus shows inverted value, not a stale one
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : mcr_host

/* mcr_irq_pins.sv */
// Shared pin multiplexer and interrupt output driver
`timescale 1ns/100ps
module mcr_irq_pins
    import mcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    mcr_cfg_if.sink          cfg,
    input  wire logic        voltage_error,
    input  wire logic        other_group_error,
    input  wire logic        fan_drive_2,
    output logic             speed3_pin_out,
    output logic             speed3_pin_oe,
    output logic             drive2_pin_out,
    output logic             drive2_pin_oe
);

    logic  irq_active;

    // Open-drain style interrupt: only ever drives low, released otherwise
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_active <= 1'b0;
        else
            irq_active <= cfg.irq_output_enable &&                  // RULE4
                          ((cfg.voltage_group_irq_enable &&
                            voltage_error) ||                       // RULE10
                           other_group_error);                      // RULE17
    end

    always_comb
    begin
        speed3_pin_out = 1'b0;
        speed3_pin_oe  = cfg.speed3_pin_as_irq && irq_active;       // RULE11
        if (cfg.drive2_pin_as_irq)                                  // RULE12
        begin
            drive2_pin_out = 1'b0;
            drive2_pin_oe  = irq_active;                            // RULE17
        end
        else
        begin
            drive2_pin_out = fan_drive_2;
            drive2_pin_oe  = 1'b1;
        end
    end

endmodule : mcr_irq_pins

/* mcr_pkg.sv */
// Package with register map, field positions and reset values
package mcr_pkg;

    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;

    // ----------------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------------
    localparam logic [7:0]  OFS_MON_CTRL      = 8'h7C;
    localparam logic [7:0]  OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN   = 8'h7E;
    localparam logic [7:0]  OFS_DEV_CFG       = 8'h7F;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0]  RST_MON_CTRL      = 8'h40;
    localparam logic [7:0]  RST_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN   = 8'hEC;
    localparam logic [7:0]  RST_DEV_CFG       = 8'h10;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int          MC_LOW_POWER      = 0;
    localparam int          MC_MON_MODE       = 1;
    localparam int          MC_IRQ_OUT_EN     = 2;
    localparam int          MC_AVG_LO         = 5;
    localparam int          MC_AVG_MID        = 6;
    localparam int          MC_AVG_HI         = 7;
    localparam int          VI_GROUP          = 0;
    // Bits that exist as real flops in the voltage enable register
    localparam logic [7:0]  VI_IMPL_MASK      = 8'hED;
    localparam int          VI_NUM_SRC        = 5;
    localparam int          DC_SPEED3_IRQ     = 0;
    localparam int          DC_DRIVE2_IRQ     = 1;
    localparam int          DC_TEMP_VALID     = 3;
    localparam int          DC_SPINUP         = 4;
    localparam int          DC_SOFT_RESET     = 7;
    // Writable bits of the configuration register (valid, bit 2 and soft reset excluded)
    localparam logic [7:0]  DC_WR_MASK        = 8'h73;

    // ----------------------------------------------------------------------
    // Averaging counts
    // ----------------------------------------------------------------------
    localparam logic [7:0]  AVG_1             = 8'h01;
    localparam logic [7:0]  AVG_8             = 8'h08;
    localparam logic [7:0]  AVG_16            = 8'h10;
    localparam logic [7:0]  AVG_32            = 8'h20;
    localparam logic [7:0]  AVG_128           = 8'h80;

endpackage : mcr_pkg

/* mcr_regs.sv */
// Monitor control register bank top level
`timescale 1ns/100ps
// --------------------------------------------------------------------------
// How it works
// RULE1: Lock set makes all three registers ignore writes.
// RULE2: Monitor control bit 0 picks sleep (0) or shutdown (1).
// RULE3: Bit 1 picks continuous (0) or cycle (1) monitoring.
// RULE4: Bit 2 enables the interrupt pin function; off by default.
// RULE5: Software keeps reserved bits 3 and 4 at zero.
// RULE6: Averaging field bits 7:5 priority encoded; bit 7 gives 32.
// RULE7: Averages per field: 000 128/8, 001 16/1, 01x 16, 1xx 32.
// RULE8: Averaging field resets to 010, sixteen averages everywhere.
// RULE9: Voltage enable bits let each voltage error set status.
// RULE10: Voltage group bit lets voltage errors pull interrupt low.
// RULE11: Config bit 0 selects speed input 3 or interrupt pin.
// RULE12: Config bit 1 selects drive output 2 or interrupt pin.
// RULE13: Temperature valid bit reads one once readings are valid.
// RULE14: Spin-up reduction enable bit, set by default.
// RULE15: Software keeps config bits 5 and 6 at defaults.
// RULE16: Writing soft reset resets registers then clears itself.
// RULE17: Interrupt only on selected pin, low while enabled error active.
// --------------------------------------------------------------------------
module mcr_regs
    import mcr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic                lock,
    input  wire logic                temp_valid_in,
    input  wire logic [VI_NUM_SRC-1:0] voltage_errors_raw,
    input  wire logic                other_group_error,
    input  wire logic                fan_drive_2,
    output logic                     low_power_select,
    output logic                     monitor_mode_select,
    output logic                     spinup_reduction_enable,
    output logic [VI_NUM_SRC-1:0]    voltage_status_set,
    output logic [7:0]               remote_avg_count,
    output logic [7:0]               local_avg_count,
    output logic                     speed3_pin_out,
    output logic                     speed3_pin_oe,
    output logic                     drive2_pin_out,
    output logic                     drive2_pin_oe
);

    // ----------------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------------
    logic [7:0]   monitor_control;
    logic [7:0]   voltage_irq_enable;
    logic [7:0]   device_configuration;
    logic         soft_reset_pending;
    logic         wr_ok;
    logic         any_reset;
    logic [VI_NUM_SRC-1:0] src_en;
    logic         voltage_error;

    mcr_cfg_if    cfg ();

    assign wr_ok     = reg_write && !lock;                          // RULE1
    // Soft reset applies on the cycle after the write, then drops
    assign any_reset = reset || soft_reset_pending;                 // RULE16

    always_ff @(posedge clk)
    begin
        if (reset)
            soft_reset_pending <= 1'b0;
        else
            soft_reset_pending <= wr_ok && reg_addr == OFS_DEV_CFG &&
                                  reg_wdata[DC_SOFT_RESET];         // RULE16
    end

    // ----------------------------------------------------------------------
    // Monitor control
    // ----------------------------------------------------------------------
    // Reserved bits 3 and 4 are stored as written; software keeps them zero
    always_ff @(posedge clk)
    begin
        if (any_reset)
            monitor_control <= RST_MON_CTRL;                        // RULE8
        else if (wr_ok && reg_addr == OFS_MON_CTRL)
            monitor_control <= reg_wdata;                           // RULE5
    end

    // ----------------------------------------------------------------------
    // Voltage interrupt enable
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (any_reset)
            voltage_irq_enable <= RST_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN;
        else if (wr_ok && reg_addr == OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN)
            voltage_irq_enable <= reg_wdata & VI_IMPL_MASK;
    end

    // ----------------------------------------------------------------------
    // Device configuration
    // ----------------------------------------------------------------------
    // Valid bit is live status and the trigger self-clears, so neither is kept
    always_ff @(posedge clk)
    begin
        if (any_reset)
            device_configuration <= RST_DEV_CFG;
        else if (wr_ok && reg_addr == OFS_DEV_CFG)
            device_configuration <= reg_wdata & DC_WR_MASK;         // RULE15
    end

    // ----------------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (reg_read)
        begin
            case (reg_addr)
                OFS_MON_CTRL:    reg_rdata <= monitor_control;
                OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN: reg_rdata <= voltage_irq_enable;
                OFS_DEV_CFG:
                begin
                    reg_rdata <= device_configuration;
                    reg_rdata[DC_TEMP_VALID] <= temp_valid_in;      // RULE13
                end
                default:         reg_rdata <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            low_power_select        <= RST_MON_CTRL[MC_LOW_POWER];
            monitor_mode_select     <= RST_MON_CTRL[MC_MON_MODE];
            spinup_reduction_enable <= RST_DEV_CFG[DC_SPINUP];
        end
        else
        begin
            low_power_select        <= monitor_control[MC_LOW_POWER]; // RULE2
            monitor_mode_select     <= monitor_control[MC_MON_MODE];  // RULE3
            spinup_reduction_enable <=
                device_configuration[DC_SPINUP];                    // RULE14
        end
    end

    // Enables in order: 2.5V, core, 5V, 12V, main
    assign src_en = {voltage_irq_enable[7:5], voltage_irq_enable[3:2]};

    always_ff @(posedge clk)
    begin
        if (reset)
            voltage_status_set <= '0;
        else
            voltage_status_set <= voltage_errors_raw & src_en;      // RULE9
    end

    assign voltage_error = |voltage_status_set;

    assign cfg.irq_output_enable        = monitor_control[MC_IRQ_OUT_EN];
    assign cfg.voltage_group_irq_enable = voltage_irq_enable[VI_GROUP];
    assign cfg.speed3_pin_as_irq        = device_configuration[DC_SPEED3_IRQ];
    assign cfg.drive2_pin_as_irq        = device_configuration[DC_DRIVE2_IRQ];
    assign cfg.averaging_select         = monitor_control[MC_AVG_HI:MC_AVG_LO];

    // ----------------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------------
    mcr_avg_decode u_avg (
        .clk              (clk),
        .reset            (reset),
        .cfg              (cfg),
        .remote_avg_count (remote_avg_count),
        .local_avg_count  (local_avg_count)
    );

    mcr_irq_pins u_pins (
        .clk               (clk),
        .reset             (reset),
        .cfg               (cfg),
        .voltage_error     (voltage_error),
        .other_group_error (other_group_error),
        .fan_drive_2       (fan_drive_2),
        .speed3_pin_out    (speed3_pin_out),
        .speed3_pin_oe     (speed3_pin_oe),
        .drive2_pin_out    (drive2_pin_out),
        .drive2_pin_oe     (drive2_pin_oe)
    );

endmodule : mcr_regs

/* mcr_regs_chk.sv */
// Port-level assertions for the monitor control register bank
`timescale 1ns/100ps
module mcr_regs_chk
    import mcr_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire logic [ADDR_W-1:0]     reg_addr,
    input wire logic [DATA_W-1:0]     reg_wdata,
    input wire logic [DATA_W-1:0]     reg_rdata,
    input wire logic                  lock,
    input wire logic                  temp_valid_in,
    input wire logic [VI_NUM_SRC-1:0] voltage_errors_raw,
    input wire logic                  other_group_error,
    input wire logic                  fan_drive_2,
    input wire logic                  low_power_select,
    input wire logic                  monitor_mode_select,
    input wire logic                  spinup_reduction_enable,
    input wire logic [VI_NUM_SRC-1:0] voltage_status_set,
    input wire logic [7:0]            remote_avg_count,
    input wire logic [7:0]            local_avg_count,
    input wire logic                  speed3_pin_out,
    input wire logic                  speed3_pin_oe,
    input wire logic                  drive2_pin_out,
    input wire logic                  drive2_pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_mon_wr;
        reg_write && !lock && reg_addr == OFS_MON_CTRL;
    endsequence
    sequence s_soft_rst;
        reg_write && !lock && reg_addr == OFS_DEV_CFG && reg_wdata[7];
    endsequence

    property p_lock_hold;
        reg_write && lock && reg_addr == OFS_MON_CTRL |=> ##1
            $stable(low_power_select) && $stable(monitor_mode_select);
    endproperty
    property p_mon_wr;
        s_mon_wr |-> ##2 low_power_select == $past(reg_wdata[0], 2)
            && monitor_mode_select == $past(reg_wdata[1], 2);
    endproperty
    property p_avg32;
        s_mon_wr ##0 reg_wdata[7] |-> ##[1:3]
            (remote_avg_count == AVG_32 && local_avg_count == AVG_32);
    endproperty
    property p_avg_pair;
        (remote_avg_count == AVG_128 && local_avg_count == AVG_8)
        || (remote_avg_count == AVG_16 && local_avg_count == AVG_1)
        || (remote_avg_count == AVG_16 && local_avg_count == AVG_16)
        || (remote_avg_count == AVG_32 && local_avg_count == AVG_32);
    endproperty
    property p_soft_rst;
        s_soft_rst |-> ##3 spinup_reduction_enable && !low_power_select
            && !monitor_mode_select && remote_avg_count == AVG_16;
    endproperty
    property p_status;
        (voltage_status_set & ~$past(voltage_errors_raw)) == '0;
    endproperty
    property p_no_irq;
        !other_group_error && voltage_status_set == '0 |=> !speed3_pin_oe;
    endproperty
    property p_speed3_low;
        speed3_pin_out == 1'b0;
    endproperty
    property p_drive2;
        drive2_pin_out |-> drive2_pin_oe && fan_drive_2;
    endproperty
    property p_cfg_read;
        reg_read && reg_addr == OFS_DEV_CFG |=> !reg_rdata[7]
            && reg_rdata[3] == $past(temp_valid_in);
    endproperty

    a_lock_hold: assert property (p_lock_hold)
        else $error("locked write changed monitor control");
    a_mon_wr: assert property (p_mon_wr)
        else $error("mode outputs do not follow write");
    a_avg32: assert property (p_avg32)
        else $error("top averaging bit did not give 32");
    a_avg_pair: assert property (p_avg_pair)
        else $error("illegal averaging count pair");
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset did not restore defaults");
    a_status: assert property (p_status)
        else $error("status set without raw error");
    a_no_irq: assert property (p_no_irq)
        else $error("interrupt without error");
    a_speed3_low: assert property (p_speed3_low)
        else $error("speed pin driven high");
    a_drive2: assert property (p_drive2)
        else $error("drive pin high without fan drive");
    a_cfg_read: assert property (p_cfg_read)
        else $error("config readback wrong");
endmodule : mcr_regs_chk

bind mcr_regs mcr_regs_chk mcr_regs_chk_inst (.clk(clk), .reset(reset),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lock(lock),
    .temp_valid_in(temp_valid_in), .voltage_errors_raw(voltage_errors_raw),
    .other_group_error(other_group_error), .fan_drive_2(fan_drive_2),
    .low_power_select(low_power_select),
    .monitor_mode_select(monitor_mode_select),
    .spinup_reduction_enable(spinup_reduction_enable),
    .voltage_status_set(voltage_status_set),
    .remote_avg_count(remote_avg_count), .local_avg_count(local_avg_count),
    .speed3_pin_out(speed3_pin_out), .speed3_pin_oe(speed3_pin_oe),
    .drive2_pin_out(drive2_pin_out), .drive2_pin_oe(drive2_pin_oe));

/* mcr_regs_test.sv */
// Self-checking testbench for the monitor control register bank
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module mcr_regs_test
    import mcr_pkg::*;
;
    logic       clk, reset, reg_write, reg_read, lock, temp_valid_in;
    logic       other_group_error, fan_drive_2, low_power_select;
    logic       monitor_mode_select, spinup_reduction_enable;
    logic       speed3_pin_out, speed3_pin_oe, drive2_pin_out, drive2_pin_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] remote_avg_count, local_avg_count;
    logic [4:0] voltage_errors_raw, voltage_status_set;
    int         fails, checks;

    mcr_regs mcr_regs_inst (.clk, .reset, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata, .lock, .temp_valid_in, .voltage_errors_raw,
        .other_group_error, .fan_drive_2, .low_power_select,
        .monitor_mode_select, .spinup_reduction_enable, .voltage_status_set,
        .remote_avg_count, .local_avg_count, .speed3_pin_out, .speed3_pin_oe,
        .drive2_pin_out, .drive2_pin_oe);
    mcr_host mcr_host_inst (.clk, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata);

    always #10 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        mcr_host_inst.rd(a, d);
        `CHK(d, e)
    endtask : rdchk

    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        logic [2:0] a;
        logic [7:0] er;
        logic [7:0] el;
        {clk, lock, temp_valid_in, other_group_error, fan_drive_2} = '0;
        voltage_errors_raw = '0;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        rdchk(OFS_MON_CTRL, RST_MON_CTRL);
        rdchk(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, RST_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN);
        rdchk(OFS_DEV_CFG, RST_DEV_CFG);
        `CHK(spinup_reduction_enable, 1'b1)
        `CHK(remote_avg_count, AVG_16)
        $display("defaults done");
        for (int i = 0; i < 8; i++)
        begin
            a = 3'(i);
            mcr_host_inst.wr(OFS_MON_CTRL, {a, 3'h0, a[1:0]});
            tick(3);
            er = a[2] ? AVG_32 : (a[1:0] != 2'h0) ? AVG_16 : AVG_128;
            el = a[2] ? AVG_32 : a[1] ? AVG_16 : a[0] ? AVG_1 : AVG_8;
            `CHK(remote_avg_count, er)
            `CHK(local_avg_count, el)
            `CHK(low_power_select, a[0])
            `CHK(monitor_mode_select, a[1])
        end
        $display("averaging done");
        mcr_host_inst.wr(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, 8'hFF);
        rdchk(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, VI_IMPL_MASK);
        mcr_host_inst.wr(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, 8'h24);
        voltage_errors_raw = 5'h1F;
        fan_drive_2 = 1'b1;
        mcr_host_inst.wr(OFS_DEV_CFG, 8'h11);
        tick(3);
        `CHK(voltage_status_set, 5'h05)
        `CHK(speed3_pin_oe, 1'b0)
        mcr_host_inst.wr(OFS_MON_CTRL, 8'h44);
        tick(3);
        `CHK(speed3_pin_oe, 1'b0)
        mcr_host_inst.wr(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, 8'h25);
        tick(3);
        `CHK(speed3_pin_oe, 1'b1)
        `CHK({drive2_pin_oe, drive2_pin_out}, 2'h3)
        mcr_host_inst.wr(OFS_DEV_CFG, 8'h12);
        tick(2);
        `CHK(speed3_pin_oe, 1'b0)
        `CHK({drive2_pin_oe, drive2_pin_out}, 2'h2)
        mcr_host_inst.wr(OFS_MON_CTRL, 8'h40);
        tick(3);
        `CHK(drive2_pin_oe, 1'b0)
        voltage_errors_raw = '0;
        other_group_error = 1'b1;
        mcr_host_inst.wr(OFS_MON_CTRL, 8'h44);
        tick(3);
        `CHK(drive2_pin_oe, 1'b1)
        other_group_error = 1'b0;
        tick(3);
        `CHK(drive2_pin_oe, 1'b0)
        temp_valid_in = 1'b1;
        rdchk(OFS_DEV_CFG, 8'h1A);
        $display("interrupt done");
        lock = 1'b1;
        mcr_host_inst.wr(OFS_MON_CTRL, 8'hFF);
        mcr_host_inst.wr(OFS_DEV_CFG, 8'h80);
        rdchk(OFS_MON_CTRL, 8'h44);
        rdchk(OFS_DEV_CFG, 8'h1A);
        rdchk(8'h7D, 8'h00);
        lock = 1'b0;
        $display("lock done");
        mcr_host_inst.wr(OFS_DEV_CFG, 8'h80);
        tick(2);
        rdchk(OFS_MON_CTRL, RST_MON_CTRL);
        rdchk(OFS_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN, RST_VOLTAGE_GROUP_IRQ_ENABLE_IRQ_EN);
        rdchk(OFS_DEV_CFG, 8'h18);
        $display("soft reset done");
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : mcr_regs_test
